// ===== src/pog_defines.vh
/*
 * Constants of the pulse-width output generator: register offsets,
 * field positions, reset values and timing figures.
 * Assumes it is included by bare name from the design files.
 */
`ifndef POG_DEFINES_VH
`define POG_DEFINES_VH

// Register word indices on the Wishbone bus (byte address bits 7:2).
`define POG_ADR_PERIOD      6'h00
`define POG_ADR_DUTY        6'h01
`define POG_ADR_CTRL        6'h02
`define POG_ADR_STATUS      6'h03

// Field positions.
`define POG_HI_MSB          15
`define POG_HI_LSB          8
`define POG_LO_MSB          1
`define POG_LO_LSB          0

// Reset values, and the control value that enables the output.
`define POG_PERIOD_RST      8'h3F
`define POG_PRE_RST         2'h0
`define POG_DUTY_HI_RST     8'h20
`define POG_DUTY_LO_RST     2'h0
`define POG_CTRL_RST        16'h0000
`define POG_CTRL_ON         16'h0001

// Prescaler encodings.
`define POG_PRE_DIV1        2'h0
`define POG_PRE_DIV4        2'h1
`define POG_PRE_DIV16       2'h2

// Timing: system clock and timer base in MHz.
`define POG_CLK_MHZ         9'd200
`define POG_BASE_MHZ        9'd32
// Half-period steps of the timer base run at twice the base rate.
`define POG_STEP_MHZ        (`POG_BASE_MHZ * 9'd2)

`endif

// ===== src/pog_tick.v
/*
 * Fractional divider that turns the system clock into a one-cycle
 * enable pulse at twice the timer base rate (one pulse per half base
 * period).
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pog_defines.vh"

module pog_tick (
    input  wire clock,
    input  wire rst_n,
    output reg  half_tick
);

    reg  [8:0] acc_q;
    wire [8:0] acc_sum;

    assign acc_sum = acc_q + `POG_STEP_MHZ;

    // The pulse train averages twice the base rate exactly; jitter is one clock.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_q     <= 9'h000;
            half_tick <= 1'b0;
        end else if (acc_sum >= `POG_CLK_MHZ) begin
            acc_q     <= acc_sum - `POG_CLK_MHZ;
            half_tick <= 1'b1;
        end else begin
            acc_q     <= acc_sum;
            half_tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== src/pog_top.v
/*
 * Pulse-width output generator with period, duty, control and status
 * registers behind a classic Wishbone slave, and one output pin.
 * Assumes one 200 MHz clock, asynchronous active-low reset, and a
 * Wishbone master that holds its request until it sees ack.
 */
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pog_defines.vh"

// Notes on behaviour
// - Timer advances from a fixed 32 MHz base, two half-steps per base period.
// - Output runs only while control holds 0x0001; otherwise held low.
// - Period register: period value bits 15:8, prescaler bits 1:0.
// - Prescaler 00 is 1:1 at reset, 01 is 1:4, 10 is 1:16.
// - Output period is (period+1) times 2 times base period times prescale.
// - At period match the timer clears and the output rises in the same step.
// - Zero duty never raises the output at rollover.
// - Duty register: upper eight duty bits at 15:8, lower two at 1:0.
// - Duty writes are accepted anytime but take effect after the period.
// - Duty is double buffered through a latch for glitch-free output.
// - High time is duty times base period over two times prescale.
// - Duty longer than the period keeps the output high throughout.
// - Bits 7:2 of period and duty registers read back as zero.
module pog_top (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         pwm_out
);

    // Byte-lane merge of a register byte with incoming write data.
    function [7:0] lane_merge;
        input [7:0] old_val;
        input [7:0] new_val;
        input       lane_en;
        begin
            lane_merge = lane_en ? new_val : old_val;
        end
    endfunction

    reg  [7:0]  period_q;
    reg  [1:0]  pre_q;
    reg  [7:0]  duty_hi_q;
    reg  [1:0]  duty_lo_q;
    reg  [15:0] ctrl_q;
    reg  [9:0]  duty_act_q;
    reg  [7:0]  timer_q;
    reg  [1:0]  phase_q;
    reg  [3:0]  pre_cnt_q;
    reg         started_q;
    reg  [3:0]  pre_lim;
    wire        half_tick;
    wire        bus_req;
    wire        bus_wr;
    wire [5:0]  word_adr;
    wire        enabled;
    wire        step;
    wire        rollover;
    wire [9:0]  count_next;
    wire [9:0]  duty_buf;
    wire [7:0]  duty_hi_new;
    wire [1:0]  duty_lo_new;

    pog_tick u_tick (
        .clock     (clock),
        .rst_n     (rst_n),
        .half_tick (half_tick)
    );

    assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr   = bus_req & wb_we_i;
    assign word_adr = wb_adr_i[7:2];
    assign enabled  = (ctrl_q == `POG_CTRL_ON);

    // Last half-step count of a phase step: prescale factor minus one.
    always @* begin
        case (pre_q)
            `POG_PRE_DIV1:  pre_lim = 4'd0;
            `POG_PRE_DIV4:  pre_lim = 4'd3;
            `POG_PRE_DIV16: pre_lim = 4'd15;
            default:        pre_lim = 4'd0;
        endcase
    end

    // Four phases of one prescaled half period make one timer count.
    assign step       = half_tick & (pre_cnt_q == pre_lim);
    assign rollover   = (timer_q == period_q) & (phase_q == 2'h3);
    assign count_next = {timer_q, phase_q} + 10'd1;

    // Duty buffer after any write in this cycle; duty_buf holds the value before it.
    assign duty_hi_new = (bus_wr && word_adr == `POG_ADR_DUTY) ?
                         lane_merge(duty_hi_q, wb_dat_i[15:8], wb_sel_i[1]) :
                         duty_hi_q;
    assign duty_lo_new = (bus_wr && word_adr == `POG_ADR_DUTY &&
                          wb_sel_i[0]) ? wb_dat_i[1:0] : duty_lo_q;
    assign duty_buf    = {duty_hi_q, duty_lo_q};

    // Register writes; ack is a one-cycle pulse one edge after request.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            period_q  <= `POG_PERIOD_RST;
            pre_q     <= `POG_PRE_RST;
            duty_hi_q <= `POG_DUTY_HI_RST;
            duty_lo_q <= `POG_DUTY_LO_RST;
            ctrl_q    <= `POG_CTRL_RST;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_wr) begin
                case (word_adr)
                    `POG_ADR_PERIOD: begin
                        period_q <= lane_merge(period_q, wb_dat_i[15:8],
                                               wb_sel_i[1]);
                        if (wb_sel_i[0]) begin
                            pre_q <= wb_dat_i[1:0];
                        end
                    end
                    `POG_ADR_DUTY: begin
                        duty_hi_q <= duty_hi_new;
                        duty_lo_q <= duty_lo_new;
                    end
                    `POG_ADR_CTRL: begin
                        ctrl_q[15:8] <= lane_merge(ctrl_q[15:8],
                                                   wb_dat_i[15:8],
                                                   wb_sel_i[1]);
                        ctrl_q[7:0]  <= lane_merge(ctrl_q[7:0],
                                                   wb_dat_i[7:0],
                                                   wb_sel_i[0]);
                    end
                    default: begin
                    end
                endcase
            end
            if (bus_req && !wb_we_i) begin
                case (word_adr)
                    `POG_ADR_PERIOD:
                        wb_dat_o <= {16'h0000, period_q, 6'h00, pre_q};
                    `POG_ADR_DUTY:
                        wb_dat_o <= {16'h0000, duty_hi_q, 6'h00,
                                     duty_lo_q};
                    `POG_ADR_CTRL:
                        wb_dat_o <= {16'h0000, ctrl_q};
                    `POG_ADR_STATUS:
                        wb_dat_o <= {16'h0000, timer_q, 5'h00, phase_q,
                                     pwm_out};
                    default:
                        wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Modulation timer, active duty latch and output pin.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            duty_act_q <= 10'h000;
            timer_q    <= 8'h00;
            phase_q    <= 2'h0;
            pre_cnt_q  <= 4'h0;
            started_q  <= 1'b0;
            pwm_out    <= 1'b0;
        end else if (!enabled) begin
            timer_q   <= 8'h00;
            phase_q   <= 2'h0;
            pre_cnt_q <= 4'h0;
            started_q <= 1'b0;
            pwm_out   <= 1'b0;
        end else if (!started_q && half_tick) begin
            // A fresh start behaves like a rollover at count zero; it waits
            // for a half-step so the first pulse is not cut short.
            started_q  <= 1'b1;
            duty_act_q <= duty_buf;
            pwm_out    <= (duty_buf != 10'h000);
        end else if (half_tick) begin
            if (step) begin
                pre_cnt_q <= 4'h0;
                if (rollover) begin
                    timer_q    <= 8'h00;
                    phase_q    <= 2'h0;
                    duty_act_q <= duty_buf;
                    pwm_out    <= (duty_buf != 10'h000);
                end else begin
                    timer_q <= count_next[9:2];
                    phase_q <= count_next[1:0];
                    // No match beyond the period keeps the pin high.
                    if (count_next == duty_act_q) begin
                        pwm_out <= 1'b0;
                    end
                end
            end else begin
                pre_cnt_q <= pre_cnt_q + 4'h1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== tb/pog_top_properties.sv
/* Bus and pin checks for pog_top.
   Assumes the bench writes control with all byte lanes enabled. */
`timescale 1ns/1ps
`default_nettype none
module pog_top_properties (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        pwm_out
);
    logic [15:0] ctrl_q;
    wire         take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         rd_ack = wb_ack_o && !wb_we_i;
    // Shadow of the control word, updated on the edge that takes the write.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 16'h0000;
        end else if (take && wb_we_i && wb_adr_i[7:2] == 6'h02) begin
            ctrl_q <= wb_dat_i[15:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_ack_cause; $rose(wb_ack_o) |-> $past(take); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_off; ctrl_q != 16'h0001 |=> !pwm_out; endproperty
    a_off: assert property (p_off) else $error("pin on while off");
    property p_rise; $rose(pwm_out) |-> $past(ctrl_q) == 16'h0001; endproperty
    a_rise: assert property (p_rise) else $error("rise while off");
    property p_rsvd; rd_ack && wb_adr_i[7:3] == 5'h00 |-> wb_dat_o[7:2] == 6'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_unmap; rd_ack && wb_adr_i[7:2] > 6'h03 |-> wb_dat_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    property p_hi_min;
        $rose(pwm_out) |=> (pwm_out || ctrl_q != 16'h0001) [*2];
    endproperty
    a_hi_min: assert property (p_hi_min) else $error("pulse too short");
    property p_lo_min;
        $fell(pwm_out) && ctrl_q == 16'h0001 |=> !pwm_out [*2];
    endproperty
    a_lo_min: assert property (p_lo_min) else $error("gap too short");
endmodule
bind pog_top pog_top_properties i_props (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_out(pwm_out));
`default_nettype wire

// ===== tb/pog_top_tb.sv
/* Self-checking bench for pog_top: registers over Wishbone, pin timing.
   Assumes a 200 MHz clock and half-steps at 64 MHz on average. */
`timescale 1ns/1ps
`default_nettype none
module pog_top_tb;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] rdat;
    logic [31:0] last;
    logic        ack;
    logic        pwm;
    int          n_fail = 0;
    int          n_checks = 0;
    int          n_cyc = 0;
    int          hi;
    int          per;
    pog_top i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .pwm_out(pwm));
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        n_cyc++;
        if (n_cyc == 30000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        n_checks++;
        if (got < exp - 2 || got > exp + 2) begin
            n_fail++;
            $display("[ERR] %0t count %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        last = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(last, e);
    endtask
    // Measures one whole pulse: high cycles and rise-to-rise cycles.
    task automatic meas;
        while (pwm === 1'b1) @(posedge clock);
        while (pwm !== 1'b1) @(posedge clock);
        hi = 0;
        while (pwm === 1'b1) begin
            @(posedge clock);
            hi++;
        end
        per = hi;
        while (pwm !== 1'b1) begin
            @(posedge clock);
            per++;
        end
    endtask
    task automatic level(input logic v);
        int bad;
        bad = 0;
        repeat (3) @(posedge clock);
        repeat (100) begin
            @(posedge clock);
            if (pwm !== v) bad++;
        end
        chk(bad, 0);
    endtask
    task automatic t_regs;
        rd(8'h00, 32'h3F00);
        rd(8'h04, 32'h2000);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h0);
        wr(8'h00, 32'hFFFF);
        rd(8'h00, 32'hFF03);
        // Only the low byte lane: prescaler changes, period value stays.
        sel <= 4'h1;
        wr(8'h00, 32'h0000);
        sel <= 4'hF;
        rd(8'h00, 32'hFF00);
        wr(8'h04, 32'hFFFF);
        rd(8'h04, 32'hFF03);
        rd(8'h10, 32'h0);
    endtask
    task automatic t_rate;
        for (int p = 0; p < 3; p++) begin
            wr(8'h00, 32'h0100 | p);
            wr(8'h04, 32'h0003);
            wr(8'h08, 32'h0001);
            meas();
            near(per, 25 << (2 * p));
            near(hi, (75 << (2 * p)) / 8);
            wr(8'h08, 32'h0000);
        end
    endtask
    task automatic t_edge;
        wr(8'h04, 32'h0000);
        wr(8'h08, 32'h0001);
        level(1'b0);
        wr(8'h08, 32'h0000);
        wr(8'h00, 32'h0000);
        wr(8'h04, 32'h0100);
        wr(8'h08, 32'h0001);
        level(1'b1);
        wr(8'h08, 32'h0003);
        level(1'b0);
    endtask
    task automatic t_dbuf;
        int t0;
        wr(8'h00, 32'h0300);
        wr(8'h04, 32'h0100);
        wr(8'h08, 32'h0001);
        while (pwm !== 1'b1) @(posedge clock);
        t0 = int'($time);
        wr(8'h04, 32'h0300);
        while (pwm === 1'b1) @(posedge clock);
        near((int'($time) - t0) / 5, 12);
        meas();
        near(hi, 37);
        near(per, 50);
        wr(8'h08, 32'h0000);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_regs();
        t_rate();
        t_edge();
        t_dbuf();
        stop_test();
    end
endmodule
`default_nettype wire
